// File: hdl/dbg_serial_pkg.sv
// Constants and types for the single-wire debug serial port
package dbg_serial_pkg;
  localparam int unsigned TCLK_DIV       = 8;     // Core clocks per target clock
  localparam int unsigned BIT_TCLK       = 16;    // Target clocks per bit
  localparam int unsigned SAMPLE_TCLK    = 10;    // Receive sample point
  localparam int unsigned SPEEDUP_1_TCLK = 7;     // Speedup point when sending one
  localparam int unsigned LOW_0_TCLK     = 13;    // Low hold when sending zero
  localparam int unsigned TIMEOUT_TCLK   = 512;   // Gap between host edges
  localparam int unsigned ACK_LOW_TCLK   = 16;    // Acknowledge low time
  localparam int unsigned ACK_GAP_TCLK   = 32;    // Least gap before acknowledge
  localparam int unsigned STEAL_CYC      = 128;   // Wait for free bus cycle
  localparam int unsigned OPC_BITS       = 8;     // Opcode width
  localparam int unsigned FLD_BITS       = 16;    // Address and data width
  localparam logic [7:0]  OPC_ACK_ON     = 8'hD5; // Acknowledge enable
  localparam logic [7:0]  OPC_ACK_OFF    = 8'hD6; // Acknowledge disable
  localparam logic [1:0]  STRAP_CYC      = 2'h2;  // Clocks after reset to catch strap
  localparam logic [2:0]  DIV_LAST       = 3'(TCLK_DIV - 1);
  localparam logic [4:0]  BIT_LAST       = 5'(BIT_TCLK - 1);
  localparam logic [4:0]  SAMPLE_AT      = 5'(SAMPLE_TCLK);
  localparam logic [4:0]  SPEEDUP_AT     = 5'(SPEEDUP_1_TCLK);
  localparam logic [4:0]  ZERO_END       = 5'(LOW_0_TCLK);
  localparam logic [4:0]  ACK_END        = 5'(ACK_LOW_TCLK);
  localparam logic [5:0]  ACK_GAP        = 6'(ACK_GAP_TCLK);
  localparam logic [9:0]  TIMEOUT_LAST   = 10'(TIMEOUT_TCLK - 1);
  localparam logic [6:0]  STEAL_LAST     = 7'(STEAL_CYC - 1);
  localparam logic [5:0]  TX_BITS        = 6'(FLD_BITS);
  typedef enum logic [2:0] {S_RX, S_MEM, S_MEM_CAP, S_FW, S_ACK_WAIT, S_ACK, S_TX} state_t;
endpackage

// File: hdl/single_wire_debug_serial_port.sv
// Device end of the single-wire debug serial port with memory and firmware hand-off
// Functional notes
// - Commands: opcode, then address and/or data
// - Every read returns a 16-bit word
// - Byte read: even high half, odd low
// - Odd word access drops address bit zero
// - Wait up to 128 cycles, then steal
// - Pin is mode strap just after reset only
// - Target clock is core clock over eight
// - Host falling edge starts bits, MSB first
// - Time out after 512 idle target clocks
// - Open drain line, speedup pulses driven high
// - Sample host bit ten target clocks in
// - Sending one: speedup at seven clocks
// - Sending zero: low 13 clocks, then speedup
// - Acknowledge: 16 clocks low plus speedup
`timescale 1ns/1ps
module single_wire_debug_serial_port
  import dbg_serial_pkg::*;
(
  input  wire logic        CLK,          // Core clock, 50 MHz
  input  wire logic        RESET,        // Asynchronous reset, active high
  input  wire logic        PIN_IN,       // Debug serial pin level
  output logic             PIN_OUT,      // Debug serial pin drive value
  output logic             PIN_OE_N,     // Debug serial pin drive enable, low drives
  output logic             SPECIAL_MODE, // Mode caught from pin after reset
  input  wire logic        MEM_FREE,     // Bus has a free cycle now
  input  wire logic [15:0] MEM_RDATA,    // Read word, valid while MEM_STB
  output logic             MEM_STB,      // One-cycle memory access strobe
  output logic             MEM_WE,       // Access is a write
  output logic [15:0]      MEM_ADDR,     // Even word address
  output logic [1:0]       MEM_BE,       // Byte enables, bit 1 is high byte
  output logic [15:0]      MEM_WDATA,    // Write word
  output logic             MEM_IN_MAP,   // Access with debug resources mapped in
  output logic             MEM_STOLEN,   // Access stole a bus cycle
  output logic             FW_REQ,       // Firmware command pending
  output logic [7:0]       FW_OPCODE,    // Firmware command opcode
  output logic [15:0]      FW_WDATA,     // Firmware command data
  input  wire logic        FW_DONE,      // Firmware finished the command
  input  wire logic [15:0] FW_RDATA      // Firmware read result
);
  // Operand decode shared by framing and dispatch
  function automatic logic has_addr(input logic [7:0] op);
    return op[7] & op[6] & ~op[4];
  endfunction
  function automatic logic is_read(input logic [7:0] op);
    return op[7] ? (has_addr(op) & op[5]) : (op[6] & op[5]);
  endfunction
  function automatic logic has_wdat(input logic [7:0] op);
    return op[7] ? (has_addr(op) & ~op[5]) : (op[6] & ~op[5]);
  endfunction
  function automatic logic [5:0] rx_len(input logic [7:0] op);
    return 6'(OPC_BITS) + (has_addr(op) ? 6'(FLD_BITS) : 6'h00) + (has_wdat(op) ? 6'(FLD_BITS) : 6'h00);
  endfunction

  logic [2:0]  div_q;                // Target clock divider
  logic        tick;                 // One target clock elapsed
  logic        s1_q, s2_q, s3_q;     // Pin synchroniser and edge history
  logic        fall;                 // Recognised falling edge
  logic [1:0]  strap_q;              // Clocks since reset release
  logic        strap_done_q, special_q;
  state_t      state_q, state_d;     // Command sequencing state
  logic        act_q, act_d;         // Bit time running
  logic [4:0]  tcnt_q, tcnt_d;       // Target clocks into bit
  logic [5:0]  nbits_q, nbits_d;     // Bits framed so far
  logic [15:0] sh_q, sh_d;           // Serial shift register
  logic [7:0]  op_q, op_d;           // Current opcode
  logic [15:0] addr_q, addr_d;       // Received address
  logic [15:0] wdat_q, wdat_d;       // Received write data
  logic [9:0]  to_q, to_d;           // Target clocks since last host edge
  logic [5:0]  gap_q, gap_d;         // Target clocks since command end
  logic [6:0]  wcnt_q, wcnt_d;       // Cycles waited for free bus
  logic        ack_en_q, ack_en_d;   // Acknowledge enabled
  logic        pout_q, pout_d, poen_q, poen_d;
  logic        stb_q, stb_d, stolen_q, stolen_d, freq_q, freq_d;

  assign tick = (div_q == DIV_LAST);
  assign fall = s3_q & ~s2_q & strap_done_q;

  // Divider, synchroniser and strap capture; the strap waits for the synchroniser to fill
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      div_q        <= 3'h0;
      s1_q         <= 1'b1;
      s2_q         <= 1'b1;
      s3_q         <= 1'b1;
      strap_q      <= 2'h0;
      strap_done_q <= 1'b0;
      special_q    <= 1'b0;
    end else begin
      div_q <= div_q + 3'h1;
      s1_q  <= PIN_IN;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      if (!strap_done_q) begin
        strap_q <= strap_q + 2'h1;
        if (strap_q == STRAP_CYC) begin
          strap_done_q <= 1'b1;
          special_q    <= ~s2_q;
        end
      end
    end
  end

  // Framing, dispatch, acknowledge and pin drive
  always_comb begin
    state_d  = state_q;
    act_d    = act_q;
    tcnt_d   = tcnt_q;
    nbits_d  = nbits_q;
    sh_d     = sh_q;
    op_d     = op_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    to_d     = to_q;
    gap_d    = gap_q;
    wcnt_d   = wcnt_q;
    ack_en_d = ack_en_q;
    stb_d    = 1'b0;
    stolen_d = stolen_q;
    freq_d   = freq_q;
    pout_d   = 1'b1;
    poen_d   = 1'b1;
    if (act_q && tick) tcnt_d = tcnt_q + 5'h1;
    if (tick && gap_q != ACK_GAP) gap_d = gap_q + 6'h1;
    if (fall) to_d = 10'h000;
    else if (tick && to_q != TIMEOUT_LAST) to_d = to_q + 10'h001;
    unique case (state_q)
      S_RX: begin
        if (fall && !act_q) begin
          act_d  = 1'b1;
          tcnt_d = 5'h00;
        end
        if (act_q && tick && tcnt_q == SAMPLE_AT) begin
          sh_d    = {sh_q[14:0], s2_q};
          nbits_d = nbits_q + 6'h01;
        end
        if (act_q && tick && tcnt_q == BIT_LAST) begin
          act_d = 1'b0;
          if (nbits_q == 6'(OPC_BITS)) op_d = sh_q[7:0];
          if (nbits_q == 6'(OPC_BITS + FLD_BITS) && has_addr(op_q)) addr_d = sh_q;
          if (nbits_q == rx_len(nbits_q == 6'(OPC_BITS) ? sh_q[7:0] : op_q)) begin
            if (has_wdat(op_q)) wdat_d = sh_q;
            gap_d   = 6'h00;
            wcnt_d  = 7'h00;
            nbits_d = 6'h00;
            if (nbits_q != 6'(OPC_BITS) && has_addr(op_q)) state_d = S_MEM;
            else if (nbits_q == 6'(OPC_BITS) && sh_q[7]) begin
              if (sh_q[7:0] == OPC_ACK_ON) ack_en_d = 1'b1;
              if (sh_q[7:0] == OPC_ACK_OFF) ack_en_d = 1'b0;
              state_d = S_ACK_WAIT;
            end else begin
              freq_d  = 1'b1;
              state_d = S_FW;
            end
          end
        end else if (nbits_q != 6'h00 && !act_q && tick && to_q == TIMEOUT_LAST) begin
          nbits_d = 6'h00;
        end
      end
      S_MEM: begin
        wcnt_d = wcnt_q + 7'h01;
        if (MEM_FREE || wcnt_q == STEAL_LAST) begin
          stb_d    = 1'b1;
          stolen_d = ~MEM_FREE;
          state_d  = S_MEM_CAP;
        end
      end
      S_MEM_CAP: begin
        if (is_read(op_q)) begin
          if (op_q[3]) sh_d = MEM_RDATA;
          else sh_d = addr_q[0] ? {8'h00, MEM_RDATA[7:0]} : {MEM_RDATA[15:8], 8'h00};
        end
        state_d = S_ACK_WAIT;
      end
      S_FW: begin
        if (FW_DONE) begin
          freq_d = 1'b0;
          if (is_read(op_q)) sh_d = FW_RDATA;
          state_d = S_ACK_WAIT;
        end
      end
      S_ACK_WAIT: begin
        if (fall) begin
          state_d = S_RX; // Short abort pulse drops the pending answer
        end else if (!ack_en_q) begin
          state_d = is_read(op_q) ? S_TX : S_RX;
        end else if (gap_q == ACK_GAP) begin
          act_d   = 1'b1;
          tcnt_d  = 5'h00;
          state_d = S_ACK;
        end
      end
      S_ACK: begin
        if (tcnt_q < ACK_END) begin
          pout_d = 1'b0;
          poen_d = 1'b0;
        end else begin
          poen_d = 1'b0;
          if (tick) begin
            act_d   = 1'b0;
            state_d = is_read(op_q) ? S_TX : S_RX;
          end
        end
      end
      S_TX: begin
        if (fall && !act_q) begin
          act_d  = 1'b1;
          tcnt_d = 5'h00;
          if (!sh_q[15]) begin
            pout_d = 1'b0;
            poen_d = 1'b0;
          end
        end
        if (act_q) begin
          if (sh_q[15] && tcnt_q == SPEEDUP_AT) poen_d = 1'b0;
          if (!sh_q[15] && tcnt_q <= ZERO_END) begin
            poen_d = 1'b0;
            pout_d = (tcnt_q == ZERO_END);
          end
          if (tick && tcnt_q == BIT_LAST) begin
            act_d   = 1'b0;
            sh_d    = {sh_q[14:0], 1'b0};
            nbits_d = nbits_q + 6'h01;
            if (nbits_q == TX_BITS - 6'h01) begin
              nbits_d = 6'h00;
              state_d = S_RX;
            end
          end
        end else if (tick && to_q == TIMEOUT_LAST && nbits_q != 6'h00) begin
          nbits_d = 6'h00;
          state_d = S_RX;
        end
      end
    endcase
  end

  // Registers of the sequencer; the pin is released in reset so the strap can be read
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_q  <= S_RX;
      act_q    <= 1'b0;
      tcnt_q   <= 5'h00;
      nbits_q  <= 6'h00;
      sh_q     <= 16'h0000;
      op_q     <= 8'h00;
      addr_q   <= 16'h0000;
      wdat_q   <= 16'h0000;
      to_q     <= 10'h000;
      gap_q    <= 6'h00;
      wcnt_q   <= 7'h00;
      ack_en_q <= 1'b0;
      pout_q   <= 1'b1;
      poen_q   <= 1'b1;
      stb_q    <= 1'b0;
      stolen_q <= 1'b0;
      freq_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      act_q    <= act_d;
      tcnt_q   <= tcnt_d;
      nbits_q  <= nbits_d;
      sh_q     <= sh_d;
      op_q     <= op_d;
      addr_q   <= addr_d;
      wdat_q   <= wdat_d;
      to_q     <= to_d;
      gap_q    <= gap_d;
      wcnt_q   <= wcnt_d;
      ack_en_q <= ack_en_d;
      pout_q   <= pout_d;
      poen_q   <= poen_d;
      stb_q    <= stb_d;
      stolen_q <= stolen_d;
      freq_q   <= freq_d;
    end
  end

  assign PIN_OUT      = pout_q;
  assign PIN_OE_N     = poen_q;
  assign SPECIAL_MODE = special_q;
  assign MEM_STB      = stb_q;
  assign MEM_WE       = ~op_q[5];
  assign MEM_ADDR     = {addr_q[15:1], 1'b0};
  assign MEM_BE       = op_q[3] ? 2'h3 : (addr_q[0] ? 2'h1 : 2'h2);
  assign MEM_WDATA    = wdat_q;
  assign MEM_IN_MAP   = op_q[2];
  assign MEM_STOLEN   = stolen_q;
  assign FW_REQ       = freq_q;
  assign FW_OPCODE    = op_q;
  assign FW_WDATA     = wdat_q;

  // Checks beside the logic
  div_period_a: assert property (@(posedge CLK) disable iff (RESET) tick |=> !tick [*7] ##1 tick)
    else $error("target clock period wrong");
  strap_release_a: assert property (@(posedge CLK) disable iff (RESET) !strap_done_q |-> PIN_OE_N)
    else $error("pin driven before strap caught");
  one_speedup_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == S_TX && act_q && sh_q[15] && !poen_q) |-> (tcnt_q == SPEEDUP_AT + 5'h1 || $past(tcnt_q) == SPEEDUP_AT))
    else $error("speedup for one at wrong time");
  zero_hold_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == S_TX && act_q && !sh_q[15] && $rose(PIN_OUT)) |-> $past(tcnt_q) == ZERO_END)
    else $error("zero low time wrong");
  ack_low_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == S_ACK && $rose(PIN_OUT)) |-> $past(tcnt_q) == ACK_END)
    else $error("acknowledge low time wrong");
  steal_bound_a: assert property (@(posedge CLK) disable iff (RESET)
    $rose(state_q == S_MEM) |-> ##[1:128] MEM_STB)
    else $error("bus cycle not taken in time");
  word_align_a: assert property (@(posedge CLK) disable iff (RESET) MEM_STB |-> !MEM_ADDR[0])
    else $error("odd word address on bus");
  byte_place_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == S_MEM_CAP && is_read(op_q) && !op_q[3] && !addr_q[0]) |=> sh_q[7:0] == 8'h00)
    else $error("even byte not in high half");
  timeout_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == S_RX && !act_q && nbits_q != 6'h00 && tick && to_q == TIMEOUT_LAST && !fall) |=> nbits_q == 6'h00)
    else $error("timeout did not drop command");
  sample_at_a: assert property (@(posedge CLK) disable iff (RESET)
    (state_q == S_RX && $changed(nbits_q) && nbits_q != 6'h00) |-> $past(tcnt_q) == SAMPLE_AT)
    else $error("bit sampled at wrong time");
  hw_read_c: cover property (@(posedge CLK) disable iff (RESET) state_q == S_MEM_CAP && is_read(op_q));
  fw_cmd_c: cover property (@(posedge CLK) disable iff (RESET) FW_REQ && FW_DONE);
  ack_c: cover property (@(posedge CLK) disable iff (RESET) state_q == S_ACK && tcnt_q == ACK_END);
  steal_c: cover property (@(posedge CLK) disable iff (RESET) MEM_STB && MEM_STOLEN);
endmodule

// File: verification/dbg_host_model.sv
// Host pod model for the single-wire debug pin
`timescale 1ns/1ps
module dbg_host_model (
  input  wire logic clk,     // Core clock
  input  wire logic pin,     // Resolved pin level
  output logic      drv_en,  // Host drives the pin
  output logic      drv_val  // Level the host drives
);
  // Idle: released, pull-up holds the line high
  initial begin
    drv_en  = 1'b0;
    drv_val = 1'b1;
  end
  // Wait a number of core clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One host bit: fall, then speedup high; a one rises early
  task automatic tx_bit(input logic b);
    drv_en  <= 1'b1;
    drv_val <= 1'b0;
    tick(b ? 32 : 104);
    drv_val <= 1'b1;
    tick(1);
    drv_en  <= 1'b0;
    tick(b ? 107 : 35);
  endtask
  // Opcode, MSB first
  task automatic send_op(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) tx_bit(v[i]);
  endtask
  // Address or data word, MSB first
  task automatic send_w(input logic [15:0] v);
    for (int i = 15; i >= 0; i--) tx_bit(v[i]);
  endtask
  // Receive one bit: short low, release, look near ten target clocks
  task automatic rx_bit(output logic b);
    drv_en  <= 1'b1;
    drv_val <= 1'b0;
    tick(24);
    drv_en  <= 1'b0;
    tick(56);
    @(negedge clk);
    b = pin;
    tick(60);
  endtask
  // Receive a whole word, MSB first
  task automatic rx_word(output logic [15:0] w);
    for (int i = 15; i >= 0; i--) rx_bit(w[i]);
  endtask
  // Wait for the device low pulse, return its length in core clocks
  task automatic wait_ack(output int lo);
    int n;
    lo = 0;
    n  = 0;
    while (pin && n < 2000) begin
      @(negedge clk);
      n++;
    end
    while (!pin && lo < 400) begin
      @(negedge clk);
      lo++;
    end
    // Two target clocks, so the device speedup ends before our next low drive
    tick(16);
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the debug serial port
`timescale 1ns/1ps
module testbench;
  import dbg_serial_pkg::*;
  logic        clk, reset, strap_low;       // Clock, reset, mode strap
  logic        pin_out, pin_oe_n, special;  // Pin drive, strap result
  logic        h_en, h_val;                 // Host drive
  wire  logic  pin;                         // Resolved line
  logic        mem_free, mem_stb, mem_we;   // Bus side
  logic [15:0] mem_rdata, mem_addr, mem_wdata;
  logic [1:0]  mem_be;
  logic        mem_map, mem_stolen;
  logic        fw_req, fw_done;             // Firmware side
  logic [7:0]  fw_opcode;
  logic [15:0] fw_wdata, fw_rdata, w;
  logic [35:0] m_rec;                       // Last bus access seen
  logic [23:0] f_rec;                       // Last firmware request seen
  logic [15:0] ram [0:15];                  // Bus stand-in storage, word index from address
  logic [15:0] fw_regs [0:7];               // Firmware register stand-in
  int          fw_cnt, lo, miscompares, cmp_count;
  // Open drain with pull-up: any low drive wins
  assign pin = ((!pin_oe_n && !pin_out) || (h_en && !h_val) || strap_low) ? 1'b0 : 1'b1;
  // Read data comes from what writes left behind, so lanes and addresses are proven end to end
  assign mem_rdata = ram[mem_addr[4:1]];
  assign fw_rdata  = fw_regs[fw_opcode[2:0]];
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  single_wire_debug_serial_port i_dut (
    .CLK(clk), .RESET(reset), .PIN_IN(pin), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n),
    .SPECIAL_MODE(special), .MEM_FREE(mem_free), .MEM_RDATA(mem_rdata), .MEM_STB(mem_stb),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_BE(mem_be), .MEM_WDATA(mem_wdata),
    .MEM_IN_MAP(mem_map), .MEM_STOLEN(mem_stolen), .FW_REQ(fw_req), .FW_OPCODE(fw_opcode),
    .FW_WDATA(fw_wdata), .FW_DONE(fw_done), .FW_RDATA(fw_rdata));
  dbg_host_model i_host (.clk(clk), .pin(pin), .drv_en(h_en), .drv_val(h_val));
  // Bus and firmware stand-ins; firmware answers ten clocks in
  always @(posedge clk) begin
    if (mem_stb) m_rec <= {mem_we, mem_be, mem_map, mem_addr, mem_wdata};
    if (mem_stb && mem_we && mem_be[1]) ram[mem_addr[4:1]][15:8] <= mem_wdata[15:8];
    if (mem_stb && mem_we && mem_be[0]) ram[mem_addr[4:1]][7:0] <= mem_wdata[7:0];
    if (fw_req && fw_cnt == 0) f_rec <= {fw_opcode, fw_wdata};
    if (fw_req && fw_cnt == 0 && fw_opcode[7:4] == 4'h4) fw_regs[fw_opcode[2:0]] <= fw_wdata;
    fw_cnt  <= fw_req ? fw_cnt + 1 : 0;
    fw_done <= fw_req && fw_cnt == 10;
  end
  // Value compare, counted
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Odd word write lands on the even address
  task automatic t_wr_odd();
    mem_free <= 1'b1;
    i_host.send_op(8'hC8);
    i_host.send_w(16'h1235);
    i_host.send_w(16'hBEEF);
    i_host.tick(150);
    chk(m_rec, {1'b1, 2'h3, 1'b0, 16'h1234, 16'hBEEF});
    $display("done: odd word write");
  endtask
  // Byte writes fill one lane each; byte reads: even in high half, odd in low, odd one stalled
  task automatic t_rd_byte();
    i_host.send_op(8'hC0);
    i_host.send_w(16'h2000);
    i_host.send_w(16'hA5FF);
    i_host.tick(150);
    chk(m_rec, {1'b1, 2'h2, 1'b0, 16'h2000, 16'hA5FF});
    i_host.send_op(8'hC4);
    i_host.send_w(16'h2001);
    i_host.send_w(16'hFF5A);
    i_host.tick(150);
    chk(m_rec, {1'b1, 2'h1, 1'b1, 16'h2000, 16'hFF5A});
    i_host.send_op(8'hE0);
    i_host.send_w(16'h2000);
    i_host.tick(150);
    i_host.rx_word(w);
    chk(36'(w), 36'h00000A500);
    chk(36'(m_rec[35:16]), {16'h0, 1'b0, 2'h2, 1'b0, 16'h2000});
    mem_free <= 1'b0;
    i_host.send_op(8'hE4);
    i_host.send_w(16'h2001);
    i_host.tick(150);
    i_host.rx_word(w);
    chk(36'(w), 36'h00000005A);
    chk(36'(m_rec[35:16]), {16'h0, 1'b0, 2'h1, 1'b1, 16'h2000});
    chk(36'(mem_stolen), 36'h1);
    mem_free <= 1'b1;
    $display("done: byte reads");
  endtask
  // Firmware write, read back of the same register, single step
  task automatic t_fw();
    i_host.send_op(8'h43);
    i_host.send_w(16'h2468);
    i_host.tick(36);
    chk(36'(f_rec), 36'h000432468);
    i_host.send_op(8'h63);
    i_host.tick(48);
    i_host.rx_word(w);
    chk(36'(w), 36'h000002468);
    chk(36'(f_rec[23:16]), 36'h63);
    i_host.send_op(8'h10);
    i_host.tick(76);
    chk(36'(f_rec[23:16]), 36'h10);
    $display("done: firmware commands");
  endtask
  // Acknowledge on an odd word read of the earlier write, then disable again
  task automatic t_ack();
    i_host.send_op(OPC_ACK_ON);
    i_host.tick(600);
    i_host.send_op(8'hE8);
    i_host.send_w(16'h1235);
    i_host.wait_ack(lo);
    chk(36'(lo >= 120 && lo <= 136), 36'h1);
    i_host.rx_word(w);
    chk(36'(w), 36'h00000BEEF);
    chk(36'(m_rec[35:16]), {16'h0, 1'b0, 2'h3, 1'b0, 16'h1234});
    i_host.send_op(OPC_ACK_OFF);
    i_host.tick(600);
    $display("done: acknowledge");
  endtask
  // Partial command dropped after a long idle gap
  task automatic t_timeout();
    i_host.tx_bit(1'b1);
    i_host.tx_bit(1'b0);
    i_host.tx_bit(1'b1);
    i_host.tick(4300);
    i_host.send_op(8'hE8);
    i_host.send_w(16'h0300);
    i_host.tick(150);
    i_host.rx_word(w);
    chk(36'(w), 36'h00000A55A);
    $display("done: timeout");
  endtask
  // Second reset in mid-run with the pin idle high: normal mode
  task automatic t_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    chk(36'({pin_oe_n, pin_out, special}), 36'h6);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    chk(36'(special), 36'h0);
    $display("done: normal mode reset");
  endtask
  // Main sequence: reset with strap low, then the scenarios
  initial begin
    reset = 1'b1;
    strap_low = 1'b1;
    mem_free = 1'b1;
    for (int i = 0; i < 16; i++) ram[i] = 16'h0000;
    for (int i = 0; i < 8; i++) fw_regs[i] = 16'h0000;
    fw_done = 1'b0;
    fw_cnt = 0;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    chk(36'({pin_oe_n, pin_out}), 36'h3);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    strap_low <= 1'b0;
    repeat (8) @(posedge clk);
    chk(36'(special), 36'h1);
    $display("done: strap");
    t_wr_odd();
    t_rd_byte();
    t_fw();
    t_ack();
    t_timeout();
    t_reset();
    final_report();
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (80000) @(posedge clk);
    miscompares++;
    final_report();
  end
endmodule
